/* verif/hisel_host.sv */
// host controller model: chip select and protocol requests on the link clock
`timescale 1ns/1ps
`default_nettype none
module hisel_host (
  input wire logic link_clk_in,
  input wire logic cs_req_in,
  input wire logic proto_req_in,
  input wire hisel_pkg::hisel_proto_type proto_sel_in,
  output logic spi_cs_n_out = 1'b0,
  output logic proto_valid_out = 1'b0,
  output hisel_pkg::hisel_proto_type proto_out = hisel_pkg::PROTO_SEND_BYTE
);
  // requests change just after a link edge and hold until the next one
  always @(posedge link_clk_in) begin
    spi_cs_n_out <= !cs_req_in;
    proto_valid_out <= proto_req_in;
    proto_out <= proto_sel_in;
  end
endmodule
`default_nettype wire

/* verif/hisel_top_bench.sv */
// self-checking bench for the host interface select block
`timescale 1ns/1ps
`default_nettype none
module hisel_top_bench;
  typedef struct {logic [2:0] s; logic [1:0] m; logic [6:0] a; logic [3:0] en;} hisel_row_type;
  logic clock_in = 1'b0, link_clk = 1'b0, rst_n = 1'b0, cs_req = 1'b0, pv_req = 1'b0;
  logic [2:0] strap = 3'h0;
  hisel_pkg::hisel_proto_type psel = hisel_pkg::PROTO_SEND_BYTE, pr;
  hisel_pkg::hisel_mode_type mode;
  logic cs_n, pv, rdy, smb_en, spi_en, three, link_en, sel, pok;
  logic [6:0] saddr, laddr;
  int failures = 0;
  int n_compared = 0;
  hisel_row_type rows [8] = '{'{3'h0, 2'h0, 7'h00, 4'h4}, '{3'h1, 2'h1, 7'h00, 4'h6},
    '{3'h2, 2'h2, 7'h00, 4'h1}, '{3'h3, 2'h3, 7'h2c, 4'h8}, '{3'h4, 2'h3, 7'h2b, 4'h8},
    '{3'h5, 2'h3, 7'h2a, 4'h8}, '{3'h6, 2'h3, 7'h29, 4'h8}, '{3'h7, 2'h3, 7'h28, 4'h8}};
  // core clock and an unrelated link clock
  initial forever #12.5 clock_in = !clock_in;
  initial begin
    #7;
    forever #24 link_clk = !link_clk;
  end
  hisel_host u_host (.link_clk_in(link_clk), .cs_req_in(cs_req), .proto_req_in(pv_req),
    .proto_sel_in(psel), .spi_cs_n_out(cs_n), .proto_valid_out(pv), .proto_out(pr));
  hisel_top #(.QUIET_CYCLES(40)) u_dut (.clock_in(clock_in), .rst_n_in(rst_n),
    .interface_strap_pin_in(strap), .link_clk_in(link_clk), .spi_cs_n_in(cs_n),
    .proto_valid_in(pv), .proto_in(pr), .mode_out(mode), .smbus_addr_out(saddr),
    .ready_out(rdy), .smbus_en_out(smb_en), .spi_en_out(spi_en), .spi_three_wire_out(three),
    .link_en_out(link_en), .spi_select_out(sel), .proto_ok_out(pok), .link_addr_out(laddr));
  task automatic check(input string name, input logic [6:0] seen, input logic [6:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // reset with a strap level, then wait out the quiet time
  task automatic restart(input logic [2:0] s);
    int i;
    @(posedge clock_in) rst_n <= 1'b0;
    strap <= s;
    repeat (2) @(posedge clock_in) rst_n <= 1'b1;
    repeat (3) @(posedge clock_in);
    check("early_ready", rdy, 7'h0);
    for (i = 0; i < 200 && rdy !== 1'b1; i++) @(posedge clock_in);
    check("ready", rdy, 7'h1);
    repeat (6) @(posedge link_clk);
  endtask
  // step through every protocol code with chip select asserted
  task automatic probe(input logic [5:0] ok, input logic cs_exp);
    @(posedge clock_in) cs_req <= 1'b1;
    for (int p = 0; p < 6; p++) begin
      @(posedge clock_in) psel <= hisel_pkg::hisel_proto_type'(p);
      pv_req <= 1'b1;
      repeat (6) @(posedge link_clk);
      check("proto_ok", pok, ok[p]);
      check("cs_select", sel, cs_exp);
    end
    @(posedge clock_in) pv_req <= 1'b0;
    cs_req <= 1'b0;
  endtask
  task automatic stop_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    #400000;
    failures++;
    $display("watchdog expired");
    stop_test();
  end
  initial begin
    foreach (rows[k]) begin
      restart(rows[k].s);
      check("mode", mode, rows[k].m);
      check("smbus_addr", saddr, rows[k].a);
      check("link_addr", laddr, rows[k].a);
      check("enables", {smb_en, spi_en, three, link_en}, rows[k].en);
      $display("strap row %0d done", k);
    end
    restart(hisel_pkg::STRAP_SMB_100K);
    @(posedge clock_in) strap <= hisel_pkg::STRAP_SPI4;
    probe(6'h3f, 1'b0);
    check("held_mode", mode, hisel_pkg::MODE_SMBUS);
    check("held_addr", saddr, hisel_pkg::ADDR_100K);
    $display("smbus protocols and hold done");
    restart(hisel_pkg::STRAP_LINK);
    probe(6'h0c, 1'b0);
    $display("link protocols done");
    restart(hisel_pkg::STRAP_SPI3);
    @(posedge clock_in) cs_req <= 1'b1;
    repeat (6) @(posedge link_clk);
    check("spi_select_on", sel, 7'h1);
    @(posedge clock_in) cs_req <= 1'b0;
    repeat (6) @(posedge link_clk);
    check("spi_select_off", sel, 7'h0);
    $display("spi chip select done");
    stop_test();
  end
endmodule
`default_nettype wire

/* verilog/hisel_cfg_if.sv */
// carrier for the frozen selection between core and link domains
`timescale 1ns/1ps
`default_nettype none
interface hisel_cfg_if;
  hisel_pkg::hisel_mode_type mode;
  logic [6:0] addr;
  logic ready; // level; mode and addr are stable before it rises
  modport core (output mode, output addr, output ready);
  modport link (input mode, input addr, input ready);
endinterface
`default_nettype wire

/* verilog/hisel_link.sv */
// link-clock side: engine enables, chip-select gating, protocol filter
`timescale 1ns/1ps
`default_nettype none
module hisel_link (
  input wire logic link_clk_in,
  input wire logic rst_n_in,
  hisel_cfg_if.link cfg,
  input wire logic spi_cs_n_in,
  input wire logic proto_valid_in,
  input wire hisel_pkg::hisel_proto_type proto_in,
  output logic smbus_en_out,
  output logic spi_en_out,
  output logic spi_three_wire_out,
  output logic link_en_out,
  output logic spi_select_out,
  output logic proto_ok_out,
  output logic [6:0] addr_out
);
  logic rdy_s1_q, rdy_s2_q, cs_s1_q, cs_s2_q;
  hisel_pkg::hisel_mode_type mode_q;
  logic on_q;

  // two-flop synchronisers for the ready level and the chip-select pin
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
    end else begin
      rdy_s1_q <= cfg.ready;
      rdy_s2_q <= rdy_s1_q;
      cs_s1_q <= spi_cs_n_in;
      cs_s2_q <= cs_s1_q;
    end
  end

  // take the stable selection once ready is seen; no engine runs before that
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      on_q <= 1'b0;
      mode_q <= hisel_pkg::MODE_SPI4;
      addr_out <= hisel_pkg::RESET_ADDR;
    end else if (rdy_s2_q && !on_q) begin
      on_q <= 1'b1; // R7
      mode_q <= cfg.mode; // R9
      addr_out <= cfg.addr;
    end
  end

  // engine enables from the held selection
  assign smbus_en_out = on_q && (mode_q == hisel_pkg::MODE_SMBUS);
  assign link_en_out = on_q && (mode_q == hisel_pkg::MODE_LINK);
  assign spi_en_out = on_q && (mode_q == hisel_pkg::MODE_SPI4 || mode_q == hisel_pkg::MODE_SPI3); // R5
  assign spi_three_wire_out = on_q && (mode_q == hisel_pkg::MODE_SPI3); // R5
  // chip select only counts in spi mode; elsewhere it is ignored
  assign spi_select_out = spi_en_out && !cs_s2_q; // R4 R5

  // protocol subset per mode; register access itself is the same in all
  always_comb begin
    proto_ok_out = 1'b0;
    if (proto_valid_in && on_q) begin
      if (mode_q == hisel_pkg::MODE_SMBUS) begin
        proto_ok_out = 1'b1; // R3
      end else if (mode_q == hisel_pkg::MODE_LINK) begin
        proto_ok_out = (proto_in == hisel_pkg::PROTO_READ_BYTE)
                    || (proto_in == hisel_pkg::PROTO_WRITE_BYTE); // R6
      end else begin
        proto_ok_out = spi_select_out && (proto_in != hisel_pkg::PROTO_SEND_BYTE)
                    && (proto_in != hisel_pkg::PROTO_RECV_BYTE); // R5
      end
    end
  end

  a_cs_ignored: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // R4
    !spi_en_out |-> !spi_select_out) else $error("chip select honoured outside spi mode");
  a_spi_select: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // R5
    (spi_en_out && $past(spi_cs_n_in, 2) == 1'b0) |-> spi_select_out)
    else $error("spi transfer not enabled with chip select low");
  a_link_subset: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // R6
    (link_en_out && proto_valid_in && proto_in == hisel_pkg::PROTO_BLOCK_WRITE) |-> !proto_ok_out)
    else $error("block protocol accepted on two-wire link");
  a_smbus_subset: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // R3
    (smbus_en_out && proto_valid_in) |-> proto_ok_out) else $error("smbus protocol refused");
  a_same_regs: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // R2
    (on_q && proto_valid_in && proto_in == hisel_pkg::PROTO_READ_BYTE && !spi_en_out)
    |-> proto_ok_out) else $error("byte read refused in a byte-capable mode");
  a_one_engine: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // R1
    $onehot0({smbus_en_out, spi_en_out, link_en_out})) else $error("two engines enabled");
endmodule
`default_nettype wire

/* verilog/hisel_pkg.sv */
// constants and types for the host interface select block
package hisel_pkg;
  // strap level codes from the pull-down comparator ladder
  localparam logic [2:0] STRAP_SPI4 = 3'h0; // 47k or less
  localparam logic [2:0] STRAP_SPI3 = 3'h1; // 56k
  localparam logic [2:0] STRAP_LINK = 3'h2; // 68k
  localparam logic [2:0] STRAP_SMB_82K = 3'h3;
  localparam logic [2:0] STRAP_SMB_100K = 3'h4;
  localparam logic [2:0] STRAP_SMB_120K = 3'h5;
  localparam logic [2:0] STRAP_SMB_150K = 3'h6;
  localparam logic [2:0] STRAP_SMB_VDD = 3'h7;
  // seven-bit slave addresses
  localparam logic [6:0] ADDR_82K = 7'h2c;
  localparam logic [6:0] ADDR_100K = 7'h2b;
  localparam logic [6:0] ADDR_120K = 7'h2a;
  localparam logic [6:0] ADDR_150K = 7'h29;
  localparam logic [6:0] ADDR_VDD = 7'h28;
  localparam logic [6:0] ADDR_NONE = 7'h00;
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int QUIET_MS = 15;
  localparam int QUIET_CYCLES = (QUIET_MS * 1000000) / CLK_PERIOD_NS; // longest, round down
  localparam int SETTLE_CYCLES = 3; // strap passes the synchroniser first
  // reset values
  localparam logic [6:0] RESET_ADDR = 7'h00;
  typedef enum logic [1:0] {
    MODE_SPI4,
    MODE_SPI3,
    MODE_LINK,
    MODE_SMBUS
  } hisel_mode_type;
  typedef enum logic [2:0] {
    PROTO_SEND_BYTE,
    PROTO_RECV_BYTE,
    PROTO_READ_BYTE,
    PROTO_WRITE_BYTE,
    PROTO_BLOCK_READ,
    PROTO_BLOCK_WRITE
  } hisel_proto_type;
endpackage

/* verilog/hisel_top.sv */
// host interface select: strap decode, power-up quiet time, link gating
// Summary of operation
// [R1] The strap level picks 4-wire spi, 3-wire spi, the two-wire link, or smbus at one of five addresses.
// [R2] Register behaviour is the same in every mode; only the transport differs.
// [R3] In smbus mode send, receive, read, write byte and i2c block read and write are accepted.
// [R4] Outside spi mode the chip-select input is ignored; the host keeps it grounded. The bench host holds it high except while cs_req is set.
// [R5] In spi mode both 3-wire and 4-wire run, and transfers are enabled only while chip select is low.
// [R6] On the two-wire link only single-register read byte and write byte are accepted.
// [R7] For up to 15 ms after power-up the device ignores the host.
// [R8] In spi mode the host waits 10 to 20 us after chip select before the first clock edge. The bench host keeps the link clock running and does not wait.
// [R9] The strap is decoded once after reset and held until the next reset.
`timescale 1ns/1ps
`default_nettype none
module hisel_top #(
  parameter int QUIET_CYCLES = hisel_pkg::QUIET_CYCLES
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [2:0] interface_strap_pin_in,
  input wire logic link_clk_in,
  input wire logic spi_cs_n_in,
  input wire logic proto_valid_in,
  input wire hisel_pkg::hisel_proto_type proto_in,
  output hisel_pkg::hisel_mode_type mode_out,
  output logic [6:0] smbus_addr_out,
  output logic ready_out,
  output logic smbus_en_out,
  output logic spi_en_out,
  output logic spi_three_wire_out,
  output logic link_en_out,
  output logic spi_select_out,
  output logic proto_ok_out,
  output logic [6:0] link_addr_out
);
  // the quiet count must leave room for the settle time and fit the counter
  if (QUIET_CYCLES <= hisel_pkg::SETTLE_CYCLES || QUIET_CYCLES > 16777215) begin : g_bad_quiet
    $error("quiet count out of range");
  end

  // last count of each timed state; settle and quiet together last QUIET_CYCLES
  localparam logic [23:0] SETTLE_LAST = 24'(hisel_pkg::SETTLE_CYCLES - 1);
  localparam logic [23:0] QUIET_LAST = 24'(QUIET_CYCLES - hisel_pkg::SETTLE_CYCLES - 1);

  // power-up sequence: let the strap settle, stay silent, then serve the host
  typedef enum logic [1:0] {ST_SETTLE, ST_QUIET, ST_READY} hisel_state_type;

  // core clock state
  hisel_state_type state_q;
  logic [2:0] strap_s1_q, strap_s2_q;
  logic [23:0] count_q;
  logic latch_now;
  logic quiet_done;
  logic ready_q;

  // decoded selection and its held copy
  hisel_pkg::hisel_mode_type mode_d;
  hisel_pkg::hisel_mode_type mode_q;
  logic [6:0] addr_d;
  logic [6:0] addr_q;

  // link clock reset release
  logic link_rst_s1_q;
  logic link_rst_n_q;

  // carrier of the frozen selection into the link domain
  hisel_cfg_if u_cfg ();

  // two-flop synchroniser for the strap level; only the second flop is read
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_s1_q <= 3'h0;
      strap_s2_q <= 3'h0;
    end else begin
      strap_s1_q <= interface_strap_pin_in;
      strap_s2_q <= strap_s1_q;
    end
  end

  // the strap is taken once, at the end of the settle time
  assign latch_now = (state_q == ST_SETTLE) && (count_q == SETTLE_LAST); // R9
  assign quiet_done = (state_q == ST_QUIET) && (count_q == QUIET_LAST); // R7

  // strap level to mode and slave address
  always_comb begin
    mode_d = hisel_pkg::MODE_SMBUS;
    addr_d = hisel_pkg::ADDR_NONE;
    if (strap_s2_q == hisel_pkg::STRAP_SPI4) begin
      mode_d = hisel_pkg::MODE_SPI4; // R1
    end else if (strap_s2_q == hisel_pkg::STRAP_SPI3) begin
      mode_d = hisel_pkg::MODE_SPI3; // R1
    end else if (strap_s2_q == hisel_pkg::STRAP_LINK) begin
      mode_d = hisel_pkg::MODE_LINK; // R1
    end else if (strap_s2_q == hisel_pkg::STRAP_SMB_82K) begin
      addr_d = hisel_pkg::ADDR_82K; // R1
    end else if (strap_s2_q == hisel_pkg::STRAP_SMB_100K) begin
      addr_d = hisel_pkg::ADDR_100K; // R1
    end else if (strap_s2_q == hisel_pkg::STRAP_SMB_120K) begin
      addr_d = hisel_pkg::ADDR_120K; // R1
    end else if (strap_s2_q == hisel_pkg::STRAP_SMB_150K) begin
      addr_d = hisel_pkg::ADDR_150K; // R1
    end else begin
      addr_d = hisel_pkg::ADDR_VDD; // R1 tied to supply
    end
  end

  // power-up state machine
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_SETTLE;
    end else begin
      case (state_q)
        ST_SETTLE: begin
          if (latch_now) begin
            state_q <= ST_QUIET;
          end
        end
        ST_QUIET: begin
          if (quiet_done) begin
            state_q <= ST_READY; // R7
          end
        end
        ST_READY: begin
          state_q <= ST_READY; // left only by reset
        end
        default: begin
          state_q <= ST_SETTLE;
        end
      endcase
    end
  end

  // cycle counter shared by settle and quiet; parked once ready
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_q <= 24'h00_0000;
    end else if (latch_now || quiet_done || state_q == ST_READY) begin
      count_q <= 24'h00_0000;
    end else begin
      count_q <= count_q + 24'h00_0001;
    end
  end

  // ready level; it never falls until the next reset
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ready_q <= 1'b0;
    end else if (quiet_done) begin
      ready_q <= 1'b1; // R7
    end
  end

  // held selection; later strap changes are ignored
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_q <= hisel_pkg::MODE_SPI4;
      addr_q <= hisel_pkg::RESET_ADDR;
    end else if (latch_now) begin
      mode_q <= mode_d; // R9
      addr_q <= addr_d; // R9
    end
  end

  // core side outputs
  assign mode_out = mode_q;
  assign smbus_addr_out = addr_q;
  assign ready_out = ready_q;

  // link domain reset: asserted at once, released on the link clock
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_rst_s1_q <= 1'b0;
      link_rst_n_q <= 1'b0;
    end else begin
      link_rst_s1_q <= 1'b1;
      link_rst_n_q <= link_rst_s1_q;
    end
  end

  // mode and addr settle long before ready rises, so a level crossing suffices
  assign u_cfg.mode = mode_q;
  assign u_cfg.addr = addr_q;
  assign u_cfg.ready = ready_q;

  // link clock side: engine enables, chip select and protocol subset
  hisel_link u_link (
    .link_clk_in(link_clk_in),
    .rst_n_in(link_rst_n_q),
    .cfg(u_cfg.link),
    .spi_cs_n_in(spi_cs_n_in),
    .proto_valid_in(proto_valid_in),
    .proto_in(proto_in),
    .smbus_en_out(smbus_en_out),
    .spi_en_out(spi_en_out),
    .spi_three_wire_out(spi_three_wire_out),
    .link_en_out(link_en_out),
    .spi_select_out(spi_select_out),
    .proto_ok_out(proto_ok_out),
    .addr_out(link_addr_out)
  );

  // the strap is taken with the supply-tied level
  sequence s_latch_vdd;
    latch_now && (strap_s2_q == hisel_pkg::STRAP_SMB_VDD);
  endsequence

  // the strap is taken with the two-wire link level
  sequence s_latch_link;
    latch_now && (strap_s2_q == hisel_pkg::STRAP_LINK);
  endsequence

  // the last quiet cycle
  sequence s_quiet_end;
    (state_q == ST_QUIET) && (count_q == QUIET_LAST);
  endsequence

  a_decode_vdd: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R1
    s_latch_vdd |=> (mode_out == hisel_pkg::MODE_SMBUS && smbus_addr_out == hisel_pkg::ADDR_VDD))
    else $error("supply strap not decoded as smbus");
  a_decode_link: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R1
    s_latch_link |=> (mode_out == hisel_pkg::MODE_LINK && smbus_addr_out == hisel_pkg::ADDR_NONE))
    else $error("link strap not decoded");
  a_addr_unused: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R1
    (mode_out != hisel_pkg::MODE_SMBUS) |-> (smbus_addr_out == hisel_pkg::ADDR_NONE))
    else $error("slave address set outside smbus mode");
  a_ready_time: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R7
    s_quiet_end |=> ready_out) else $error("ready late after quiet time");
  a_ready_early: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R7
    $rose(ready_out) |-> ($past(state_q) == ST_QUIET && $past(count_q) == QUIET_LAST))
    else $error("ready before quiet time ended");
  a_ready_sticky: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R7
    ready_out |=> ready_out) else $error("ready fell without reset");
  a_select_held: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R9
    ready_out |=> ($stable(mode_out) && $stable(smbus_addr_out)))
    else $error("selection changed after decode");
endmodule
`default_nettype wire
